// ---- sim/dual_bus_slot_delineation_tb.sv ----
// Purpose: Self-checking bench for receive slot delineation.
// Assumes: Event pulses are counted by a monitor on every rising edge.
// Notes:   Offset 6'h3F in the table means the offset is not judged.
`timescale 1ns/1ns
module dual_bus_slot_delineation_tb
	import slot_delin_pkg::*;
;
	logic       clk_sys;
	logic       rstn;
	logic       method_hcs;
	logic [3:0] loss_miss_threshold;
	logic [3:0] confirm_threshold;
	logic       octet_valid;
	logic [7:0] octet_data;
	logic       h4_valid;
	logic [7:0] h4_data;
	logic       in_sync;
	logic       sync_lost;
	logic       sync_found;
	logic       slot_start;
	logic [5:0] slot_offset;
	int         errors;
	int         samples_checked;
	int         n_found;
	int         n_lost;
	int         n_slot;
	localparam logic [5:0] H4_IND [9] = '{6'h0A, 6'h02, 6'h3C, 6'h27, 6'h14, 6'h0C, 6'h00,
		6'h32, 6'h2A};
	localparam logic [5:0] H4_USE [9] = '{6'h3F, 6'h02, 6'h2F, 6'h27, 6'h1F, 6'h0C, 6'h04,
		6'h3F, 6'h2A};

	path_term_model i_path_term_model (.clk_sys, .octet_valid, .octet_data, .h4_valid, .h4_data);
	slot_delineation i_slot_delineation (.clk_sys, .rstn, .method_hcs, .loss_miss_threshold,
		.confirm_threshold, .octet_valid, .octet_data, .h4_valid, .h4_data, .in_sync,
		.sync_lost, .sync_found, .slot_start, .slot_offset);

	// Free-running 250 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Pulse counters; counting avoids sampling a pulse in a racy step.
	always @(posedge clk_sys) begin
		if (sync_found === 1'b1) n_found++;
		if (sync_lost === 1'b1) n_lost++;
		if (slot_start === 1'b1) n_slot++;
	end

	////////////////////////////////////////////////////////////////////////////
	task check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task finish_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// Configuration only counts when captured after a reset.
	task do_reset(input logic hcs, input logic [3:0] loss, input logic [3:0] conf);
		rstn <= 1'b0;
		method_hcs <= hcs;
		loss_miss_threshold <= loss;
		confirm_threshold <= conf;
		repeat (4) i_path_term_model.idle();
		n_found = 0;
		n_lost = 0;
		n_slot = 0;
		rstn <= 1'b1;
		repeat (2) i_path_term_model.idle();
	endtask : do_reset

	// Let pulses land, judge at the falling edge, then realign.
	task expect_state(input int found, input int lost, input logic sync, input logic [5:0] off);
		repeat (2) i_path_term_model.idle();
		@(negedge clk_sys);
		check(8'(n_found), 8'(found));
		check(8'(n_lost), 8'(lost));
		check({7'h00, in_sync}, {7'h00, sync});
		if (off != 6'h3F) check({2'b00, slot_offset}, {2'b00, off});
		@(posedge clk_sys);
	endtask : expect_state

	////////////////////////////////////////////////////////////////////////////
	// Lock, illegal and wrong indicators, recovery, loss and relock.
	task test_h4_offsets();
		int i;
		do_reset(1'b0, LOSS_DEFAULT, CONFIRM_DEFAULT);
		for (i = 0; i < 9; i++) begin
			i_path_term_model.put_h4(H4_IND[i]);
			repeat ((i == 1) ? 60 : 2) i_path_term_model.put_octet(8'hC3);
			expect_state((i > 0) + (i == 8), (i > 6), (i > 0) && (i != 7),
				H4_USE[i]);
		end
		check(8'(n_slot), 8'h02);
	endtask : test_h4_offsets

	// A bad check in presync restarts the hunt before confirmation.
	task test_hcs_lock();
		int i;
		do_reset(1'b1, LOSS_DEFAULT, 4'h3);
		for (i = 0; i < 7; i++) begin
			i_path_term_model.put_slot(i != 2);
			expect_state((i == 6), 0, (i == 6), 6'h00);
		end
	endtask : test_hcs_lock

	// One good header breaks a run of misses; seven in a row lose lock.
	task test_hcs_loss();
		int i;
		method_hcs <= 1'b0;
		for (i = 0; i < 14; i++) begin
			i_path_term_model.put_slot(i == 6);
			expect_state(1, (i == 13), (i != 13), 6'h00);
		end
		check(8'(n_slot), 8'h0E);
	endtask : test_hcs_loss

	// Zero thresholds act as one: one counted good check locks, one bad check loses.
	// This also proves that the loss threshold is taken from the input at capture.
	task test_hcs_zero_thr();
		int i;
		do_reset(1'b1, 4'h0, 4'h0);
		for (i = 0; i < 3; i++) begin
			i_path_term_model.put_slot(i != 2);
			expect_state((i > 0), (i == 2), (i == 1), 6'h00);
		end
		check(8'(n_slot), 8'h01);
	endtask : test_hcs_zero_thr

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rstn = 1'b0;
		method_hcs = 1'b0;
		loss_miss_threshold = LOSS_DEFAULT;
		confirm_threshold = CONFIRM_DEFAULT;
		errors = 0;
		samples_checked = 0;
		@(posedge clk_sys);
		test_h4_offsets();
		test_hcs_lock();
		test_hcs_loss();
		test_hcs_zero_thr();
		finish_test();
	end

	// Watchdog; the run needs about fifteen hundred cycles.
	initial begin
		#40000;
		errors++;
		finish_test();
	end
endmodule : dual_bus_slot_delineation_tb

// ---- sim/path_term_model.sv ----
// Purpose: Path termination model that hands payload octets and H4 over.
// Assumes: Each task is entered just after a rising edge.
// Notes:   Unqualified data lines toggle so a stale value is never trusted.
`timescale 1ns/1ns
module path_term_model (
	input  wire logic clk_sys,
	output logic      octet_valid,
	output logic [7:0] octet_data,
	output logic      h4_valid,
	output logic [7:0] h4_data
);
	// Quiet lines at time zero.
	initial begin
		octet_valid = 1'b0;
		octet_data  = 8'h00;
		h4_valid    = 1'b0;
		h4_data     = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// One payload octet; never on the same cycle as H4.
	task put_octet(input logic [7:0] d);
		octet_valid <= 1'b1;
		octet_data  <= d;
		h4_valid    <= 1'b0;
		h4_data     <= ~h4_data;
		@(posedge clk_sys);
	endtask : put_octet

	// Link status bits set to 01, so only the low six bits may be read.
	task put_h4(input logic [5:0] ind);
		octet_valid <= 1'b0;
		octet_data  <= ~octet_data;
		h4_valid    <= 1'b1;
		h4_data     <= {2'b01, ind};
		@(posedge clk_sys);
	endtask : put_h4

	// A stalled cycle with nothing qualified.
	task idle();
		octet_valid <= 1'b0;
		octet_data  <= ~octet_data;
		h4_valid    <= 1'b0;
		h4_data     <= ~h4_data;
		@(posedge clk_sys);
	endtask : idle

	// Zero header; a bad slot carries the raw check without the coset.
	task put_slot(input logic good);
		repeat (3) put_octet(8'h00);
		put_octet(good ? 8'h55 : 8'h00);
		repeat (49) put_octet(8'h00);
	endtask : put_slot
endmodule : path_term_model

// ---- sim/slot_delineation_asserts.sv ----
// Purpose: Timing checks on the delineation outputs of one bus.
// Assumes: Bound to slot_delineation; a single clock domain.
// Notes:   Every event pulse is judged against the strobe that caused it.
`timescale 1ns/1ns
module slot_delineation_asserts
	import slot_delin_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       method_hcs,
	input wire logic       octet_valid,
	input wire logic       h4_valid,
	input wire logic       in_sync,
	input wire logic       sync_lost,
	input wire logic       sync_found,
	input wire logic       slot_start,
	input wire logic [5:0] slot_offset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic cfg_seen_q;
	logic mode_hcs_q;

	// Method as the block froze it; the input pin may move after capture.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_seen_q <= 1'b0;
			mode_hcs_q <= 1'b0;
		end else if (!cfg_seen_q) begin
			cfg_seen_q <= 1'b1;
			mode_hcs_q <= method_hcs;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Events are single pulses that sit exactly on a state change.
	AST_LOST_ONE: assert property (sync_lost |=> !sync_lost)
		else $error("sync lost longer than one cycle");
	AST_FOUND_ONE: assert property (sync_found |=> !sync_found)
		else $error("sync found longer than one cycle");
	AST_NO_BOTH: assert property (!(sync_found && sync_lost))
		else $error("found and lost together");
	AST_FOUND_RISE: assert property (sync_found |-> in_sync && !$past(in_sync))
		else $error("found without rise of in_sync");
	AST_LOST_FALL: assert property (sync_lost |-> !in_sync && $past(in_sync))
		else $error("lost without fall of in_sync");
	AST_RISE_FOUND: assert property ($rose(in_sync) |-> sync_found)
		else $error("in_sync rose silently");
	AST_FALL_LOST: assert property ($fell(in_sync) |-> sync_lost)
		else $error("in_sync fell silently");
	AST_EVENT_CAUSE: assert property ((sync_found || sync_lost) |->
		$past(octet_valid || h4_valid))
		else $error("event without a strobe");

	////////////////////////////////////////////////////////////////////////////
	// Boundaries only while locked; the offset only moves on an indicator.
	AST_SLOT_LOCKED: assert property (slot_start |-> in_sync && $past(octet_valid))
		else $error("slot start while unlocked");
	AST_HCS_SPACING: assert property (mode_hcs_q && slot_start |=> !slot_start [*8])
		else $error("slot starts too close");
	AST_OFFSET_LEGAL: assert property (in_sync |-> slot_offset <= OFFSET_MAX)
		else $error("illegal offset in use");
	AST_OFFSET_HOLD: assert property (!$past(h4_valid) |-> $stable(slot_offset))
		else $error("offset moved without an indicator");
endmodule : slot_delineation_asserts

bind slot_delineation slot_delineation_asserts i_slot_delineation_asserts (
	.clk_sys, .rstn, .method_hcs, .octet_valid, .h4_valid,
	.in_sync, .sync_lost, .sync_found, .slot_start, .slot_offset
);

// ---- src/hcs_check.sv ----
// Purpose: Tests every octet position as the check octet of a slot header.
// Assumes: Octets arrive in order; the window holds the three before.
// Notes:   Window fills after reset; no verdict until three octets are held.
`timescale 1ns/1ns
module hcs_check
	import slot_delin_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	hcs_if.chk_side   hcs
);

	logic [23:0] win_q;
	logic [1:0]  fill_q;
	logic [7:0]  crc_w;

	////////////////////////////////////////////////////////////////////////////
	// Bitwise CRC over the protected octets, first octet first, MSB first.
	function automatic logic [7:0] crc8(input logic [23:0] data);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ data[i];
			c  = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction : crc8

	// Verdict for the current position, with the transmit pattern removed.
	assign crc_w      = crc8(win_q);
	assign hcs.hdr_ok = hcs.octet_valid && (fill_q == HDR_PROT_LEN) &&
	                    ((hcs.octet ^ HCS_COSET) == crc_w);

	// Sliding window of the last three octets; fill saturates.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			win_q  <= 24'h000000;
			fill_q <= 2'h0;
		end else if (hcs.octet_valid) begin
			win_q <= {win_q[15:0], hcs.octet};
			if (fill_q != HDR_PROT_LEN) begin
				fill_q <= fill_q + 2'h1;
			end
		end
	end

endmodule : hcs_check

// ---- src/hcs_if.sv ----
// Purpose: Carries payload octets to the header checker and its verdict back.
// Assumes: Verdict is combinational on the octet presented in the same cycle.
// Notes:   hdr_ok is high when the presented octet closes a valid header.
`timescale 1ns/1ns
interface hcs_if;
	logic       octet_valid;
	logic [7:0] octet;
	logic       hdr_ok;

	modport src_side (output octet_valid, output octet, input hdr_ok);
	modport chk_side (input octet_valid, input octet, output hdr_ok);
endinterface : hcs_if

// ---- src/slot_delin_pkg.sv ----
// Purpose: Shared constants and state types for receive slot delineation.
// Assumes: One bus per instance; octet-wide payload stream on clk_sys.
// Notes:   Every slot, check and threshold constant of the design files is named here once.
package slot_delin_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Payload and slot geometry.
	localparam int unsigned PAYLOAD_LEN  = 2340;
	localparam logic [5:0]  SLOT_LAST    = 6'h34;   // Slot length 53, minus one.
	localparam logic [5:0]  OFFSET_STEP  = 6'h2D;   // Step of 45 per container.
	localparam logic [5:0]  OFFSET_STEP2 = 6'h25;   // Two steps: 90 mod 53 is 37.
	localparam logic [5:0]  OFFSET_MAX   = 6'h34;   // Highest legal indicator, 52.
	localparam logic [6:0]  SLOT_LEN_W   = 7'h35;   // Slot length 53 for sums.
	localparam int unsigned IND_MSB      = 5;       // Indicator is bits 5..0.

	////////////////////////////////////////////////////////////////////////////
	// Header check.
	localparam logic [7:0]  CRC_POLY     = 8'h07;   // x^8 + x^2 + x + 1.
	localparam logic [7:0]  HCS_COSET    = 8'h55;   // Pattern added on transmit.
	localparam logic [1:0]  HDR_PROT_LEN = 2'h3;    // Protected header octets.
	localparam logic [5:0]  SLOT_HEAD_POS = 6'h32;  // Slot start, 3 before check.

	////////////////////////////////////////////////////////////////////////////
	// Threshold defaults.
	localparam logic [3:0]  LOSS_DEFAULT    = 4'h7;
	localparam logic [3:0]  CONFIRM_DEFAULT = 4'h6;

	////////////////////////////////////////////////////////////////////////////
	// State machines, one-hot.
	typedef enum logic [1:0] {
		offset_locked_state   = 2'b01,
		offset_unlocked_state = 2'b10
	} offset_state_t;

	typedef enum logic [2:0] {
		header_locked_state  = 3'b001,
		header_presync_state = 3'b010,
		header_hunt_state    = 3'b100
	} header_state_t;

endpackage : slot_delin_pkg

// ---- src/slot_delineation.sv ----
// Purpose: Receive slot delineation for one bus, by indicator or by header.
// Assumes: Upstream logic on clk_sys strobes payload octets and the H4 octet.
// Notes:   Instantiate once per bus; each instance runs its own machines.
// Function
// - Two selectable methods find slot boundaries: offset indicator or header check.
// - Boundaries are re-found in every container payload, since 2340 is not 53 multiple.
// - Expected indicator advances by 45 modulo 53 per container.
// - An out-of-range indicator is handled as an unexpected one.
// - Each bus receiver has its own independent delineation machine.
// - Indicator machine has locked and unlocked states, starting unlocked.
// - Locked: use matching indicator, else substitute the expected value.
// - After one miss, accept a value matching either previous-based expectation.
// - Matching neither expectation: go unlocked and pulse sync lost.
// - Unlocked: match previous plus 45 mod 53 to lock and pulse found.
// - Check three header octets against the fourth, CRC x^8+x^2+x+1.
// - Header machine has locked, presync and hunt states, starting in hunt.
// - Default thresholds: seven bad headers to lose, six good to confirm.
// - Locked: one check per slot; threshold misses return to hunt, pulse lost.
// - Presync: one check per slot; any failure returns to hunt.
// - Presync: threshold good headers in a row lock and pulse found.
// - Hunt: test every octet position; first good header enters presync.
// - Indicator is the low six bits of H4, distance to next boundary.
// - Legal indicator values are 0 to 52.
`timescale 1ns/1ns
module slot_delineation
	import slot_delin_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       method_hcs,
	input  wire logic [3:0] loss_miss_threshold,
	input  wire logic [3:0] confirm_threshold,
	input  wire logic       octet_valid,
	input  wire logic [7:0] octet_data,
	input  wire logic       h4_valid,
	input  wire logic [7:0] h4_data,
	output logic            in_sync,
	output logic            sync_lost,
	output logic            sync_found,
	output logic            slot_start,
	output logic [5:0]      slot_offset
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic          cfg_done_q;
	logic          hcs_mode_q;
	logic [3:0]    loss_thr_q;
	logic [3:0]    conf_thr_q;
	logic [3:0]    loss_eff;
	logic [3:0]    conf_eff;

	offset_state_t ost_q;
	offset_state_t ost_d;
	logic [5:0]    prev1_q;
	logic [5:0]    prev2_q;
	logic          prev1_ok_q;
	logic          prev2_ok_q;
	logic          miss_q;
	logic          miss_d;
	logic [5:0]    bcnt_q;
	logic [5:0]    used_d;
	logic          use_ok_d;
	logic          o_lost_d;
	logic          o_found_d;

	header_state_t hst_q;
	header_state_t hst_d;
	logic [5:0]    ph_q;
	logic [5:0]    ph_d;
	logic [3:0]    good_q;
	logic [3:0]    good_d;
	logic [3:0]    bad_q;
	logic [3:0]    bad_d;
	logic          h_lost_d;
	logic          h_found_d;

	logic [5:0]    ind;
	logic          ind_legal;
	logic [5:0]    exp1;
	logic [5:0]    exp2;
	logic          match1;
	logic          match2;
	logic          h4_take;
	logic          hcs_take;
	logic          at_check;
	logic          hdr_ok;
	logic          o_bound;
	logic          h_bound;

	hcs_if hcs_bus ();

	////////////////////////////////////////////////////////////////////////////
	// Addition modulo the slot length; b is below 53, a may be an illegal raw indicator.
	function automatic logic [5:0] add_mod(input logic [5:0] a, input logic [5:0] b);
		logic [6:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= SLOT_LEN_W) begin
			s = s - SLOT_LEN_W;
		end
		return s[5:0];
	endfunction : add_mod

	////////////////////////////////////////////////////////////////////////////
	// Configuration is caught on the first edge after release and then frozen,
	// so a change mid-run cannot tear a machine between two methods.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_done_q <= 1'b0;
			hcs_mode_q <= 1'b0;
			loss_thr_q <= LOSS_DEFAULT;
			conf_thr_q <= CONFIRM_DEFAULT;
		end else if (!cfg_done_q) begin
			cfg_done_q <= 1'b1;
			hcs_mode_q <= method_hcs;
			loss_thr_q <= loss_miss_threshold;
			conf_thr_q <= confirm_threshold;
		end
	end

	// A zero threshold would never be reached; it behaves as one.
	assign loss_eff = (loss_thr_q == 4'h0) ? 4'h1 : loss_thr_q;
	assign conf_eff = (conf_thr_q == 4'h0) ? 4'h1 : conf_thr_q;

	////////////////////////////////////////////////////////////////////////////
	// Indicator decode and the two expectations.
	assign ind       = h4_data[IND_MSB:0];
	assign ind_legal = (ind <= OFFSET_MAX);
	assign exp1      = add_mod(prev1_q, OFFSET_STEP);
	assign exp2      = add_mod(prev2_q, OFFSET_STEP2);
	assign match1    = ind_legal && prev1_ok_q && (ind == exp1);
	assign match2    = ind_legal && prev2_ok_q && (ind == exp2);
	assign h4_take   = cfg_done_q && !hcs_mode_q && h4_valid;

	// Indicator machine next state and the offset put to use.
	always_comb begin
		ost_d     = ost_q;
		miss_d    = miss_q;
		used_d    = exp1;
		use_ok_d  = 1'b0;
		o_lost_d  = 1'b0;
		o_found_d = 1'b0;
		if (h4_take) begin
			case (ost_q)
				offset_locked_state: begin
					if (match1) begin
						used_d   = ind;
						use_ok_d = 1'b1;
						miss_d   = 1'b0;
					end else if (miss_q && match2) begin
						used_d   = ind;
						use_ok_d = 1'b1;
						miss_d   = 1'b0;
					end else if (!miss_q) begin
						used_d   = exp1;
						use_ok_d = 1'b1;
						miss_d   = 1'b1;
					end else begin
						ost_d    = offset_unlocked_state;
						o_lost_d = 1'b1;
						miss_d   = 1'b0;
					end
				end
				offset_unlocked_state: begin
					if (match1) begin
						ost_d     = offset_locked_state;
						o_found_d = 1'b1;
						used_d    = ind;
						use_ok_d  = 1'b1;
						miss_d    = 1'b0;
					end
				end
				default: begin
					ost_d  = offset_unlocked_state;
					miss_d = 1'b0;
				end
			endcase
		end
	end

	// Indicator history; the raw received value is kept even when illegal.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ost_q      <= offset_unlocked_state;
			miss_q     <= 1'b0;
			prev1_q    <= 6'h00;
			prev2_q    <= 6'h00;
			prev1_ok_q <= 1'b0;
			prev2_ok_q <= 1'b0;
		end else if (h4_take) begin
			ost_q      <= ost_d;
			miss_q     <= miss_d;
			prev2_q    <= prev1_q;
			prev2_ok_q <= prev1_ok_q;
			prev1_q    <= ind;
			prev1_ok_q <= ind_legal;
		end
	end

	// Boundary countdown, reloaded at each H4 whose offset is put to use, so each container stands alone.
	// Payload octets are not expected in the same cycle as the H4 octet.
	assign o_bound = octet_valid && (bcnt_q == 6'h00);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bcnt_q <= SLOT_LAST;
		end else if (h4_take && use_ok_d) begin
			bcnt_q <= used_d;
		end else if (octet_valid) begin
			bcnt_q <= o_bound ? SLOT_LAST : (bcnt_q - 6'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Header checker sees every payload octet.
	assign hcs_bus.octet_valid = octet_valid;
	assign hcs_bus.octet       = octet_data;
	assign hdr_ok              = hcs_bus.hdr_ok;

	hcs_check u_hcs_check (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.hcs     (hcs_bus.chk_side)
	);

	assign hcs_take = cfg_done_q && hcs_mode_q && octet_valid;
	assign at_check = (ph_q == SLOT_LAST);
	assign ph_d     = at_check ? 6'h00 : (ph_q + 6'h01);
	assign h_bound  = octet_valid && (ph_d == SLOT_HEAD_POS);

	// Header machine next state; outside hunt only one position per slot counts.
	always_comb begin
		hst_d     = hst_q;
		good_d    = good_q;
		bad_d     = bad_q;
		h_lost_d  = 1'b0;
		h_found_d = 1'b0;
		if (hcs_take) begin
			case (hst_q)
				header_hunt_state: begin
					if (hdr_ok) begin
						hst_d  = header_presync_state;
						good_d = 4'h0;
					end
				end
				header_presync_state: begin
					if (at_check && !hdr_ok) begin
						hst_d = header_hunt_state;
					end else if (at_check && ((good_q + 4'h1) >= conf_eff)) begin
						hst_d     = header_locked_state;
						h_found_d = 1'b1;
						bad_d     = 4'h0;
					end else if (at_check) begin
						good_d = good_q + 4'h1;
					end
				end
				header_locked_state: begin
					if (at_check && hdr_ok) begin
						bad_d = 4'h0;
					end else if (at_check && ((bad_q + 4'h1) >= loss_eff)) begin
						hst_d    = header_hunt_state;
						h_lost_d = 1'b1;
					end else if (at_check) begin
						bad_d = bad_q + 4'h1;
					end
				end
				default: begin
					hst_d = header_hunt_state;
				end
			endcase
		end
	end

	// Slot phase restarts on the header that ends the hunt.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hst_q  <= header_hunt_state;
			ph_q   <= 6'h00;
			good_q <= 4'h0;
			bad_q  <= 4'h0;
		end else if (hcs_take) begin
			hst_q  <= hst_d;
			ph_q   <= (hst_q == header_hunt_state && hdr_ok) ? 6'h00 : ph_d;
			good_q <= good_d;
			bad_q  <= bad_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs, selected by the frozen method.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			in_sync     <= 1'b0;
			sync_lost   <= 1'b0;
			sync_found  <= 1'b0;
			slot_start  <= 1'b0;
			slot_offset <= 6'h00;
		end else if (hcs_mode_q) begin
			in_sync    <= cfg_done_q && (hst_d == header_locked_state);
			sync_lost  <= h_lost_d;
			sync_found <= h_found_d;
			slot_start <= hcs_take && h_bound && (hst_q == header_locked_state);
		end else begin
			in_sync    <= cfg_done_q && (ost_d == offset_locked_state);
			sync_lost  <= o_lost_d;
			sync_found <= o_found_d;
			slot_start <= cfg_done_q && !h4_take && o_bound &&
			              (ost_q == offset_locked_state);
			if (h4_take && use_ok_d) begin
				slot_offset <= used_d;
			end
		end
	end

endmodule : slot_delineation
